// *** logic/qarx_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module qarx_top #(
    parameter logic [6:0] GAP_FAST_LEN = qarx_pkg::GAP_FAST,
    parameter logic [6:0] GAP_SLOW_LEN = qarx_pkg::GAP_SLOW
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Mode straps
    input  wire logic       mode_hw,
    input  wire logic       parity_en,
    // Processor bus
    input  wire logic       cs_n,
    input  wire logic       dir_or_scan_hold,
    input  wire logic       func_addr_low,
    input  wire logic       func_addr_high,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    // Receive lines
    input  wire logic       zero_pulse_in_ch0,
    input  wire logic       one_pulse_in_ch0,
    input  wire logic       zero_pulse_in_ch1,
    input  wire logic       one_pulse_in_ch1,
    input  wire logic       zero_pulse_in_ch2,
    input  wire logic       one_pulse_in_ch2,
    input  wire logic       zero_pulse_in_ch3,
    input  wire logic       one_pulse_in_ch3,
    // Transmit lines or scanned channel number
    output logic            zero_line_out_or_chan_lsb,
    output logic            one_line_out_or_chan_msb,
    // Interrupt or speed select pin
    input  wire logic       int_or_speed_sel_in,
    output logic            int_or_speed_sel_out,
    output logic            int_or_speed_sel_oe
);
    import qarx_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        qarx_pins_t                 sy1;
        qarx_pins_t                 sy2;
        logic                       cs_prev;
        logic [7:0]                 ctrl;
        logic [7:0]                 stat;
        logic [7:0]                 div;
        logic [NCH-1:0][7:0]        label;
        logic [NCH-1:0][7:0]        sync;
        logic [NCH-1:0]             reading;
        logic [1:0]                 tx_idx;
        logic [WORD_BITS-1:0]       tx_sh;
        logic [5:0]                 tx_bits;
        logic [6:0]                 tx_cnt;
        logic                       tx_phase;
        logic [1:0]                 scan;
        logic [7:0]                 dout;
        logic                       doe;
        logic                       n0;
        logic                       n1;
        logic                       irq_oe;
        logic                       irq_lvl;
    } qarx_state_t;

    localparam logic [5:0] TX_LAST_BIT = 6'(WORD_BITS - 1);

    qarx_state_t                          s;
    qarx_state_t                          next_s;
    qarx_pins_t                           pin_raw;
    qarx_pins_t                           p;
    logic                                 hw;
    logic                                 acc;
    logic                                 rd;
    logic                                 wr;
    logic [1:0]                           rch;
    logic [6:0]                           half;
    logic [NCH-1:0]                       chan_hold;
    logic [NCH-1:0]                       chan_en;
    logic [NCH-1:0][6:0]                  chan_gap;
    logic [NCH-1:0][LABEL_BITS-1:0]       chan_label;
    logic [NCH-1:0][DATA_BITS-1:0]        chan_data;
    logic [NCH-1:0]                       chan_valid;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] first_sel(input logic [NCH-1:0] m);
        first_sel = 2'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (m[i]) begin
                first_sel = 2'(i);
            end
        end
    endfunction

    function automatic logic [7:0] pick_byte(input logic [DATA_BITS-1:0] d, input int i);
        return d[LABEL_BITS*i +: LABEL_BITS];
    endfunction

    // ------------------------------------------------------------
    // Pins and decode
    // ------------------------------------------------------------
    assign pin_raw = {mode_hw, parity_en, int_or_speed_sel_in, cs_n, dir_or_scan_hold,
                      func_addr_high, func_addr_low, data_in,
                      one_pulse_in_ch3, one_pulse_in_ch2, one_pulse_in_ch1, one_pulse_in_ch0,
                      zero_pulse_in_ch3, zero_pulse_in_ch2, zero_pulse_in_ch1, zero_pulse_in_ch0};
    assign p   = s.sy2;
    assign hw  = p.mode_hw;
    // One access per chip-select low period, taken at its first cycle
    assign acc = !p.cs_n && s.cs_prev;
    assign rd  = acc && (hw || p.dir_hold);
    assign wr  = acc && !hw && !p.dir_hold;
    assign rch = hw ? s.scan : first_sel(s.ctrl[NCH-1:0]);
    assign half = (s.div[7:1] == 7'h00) ? 7'h01 : s.div[7:1];

    // ------------------------------------------------------------
    // Receive channels
    // ------------------------------------------------------------
    for (genvar c = 0; c < NCH; c++) begin : g_chan
        assign chan_hold[c] = s.reading[c] || (hw && !p.cs_n && s.scan == 2'(c));
        assign chan_en[c]   = hw || s.sync[c][SYNC_EN];
        // Speed pin low: only the lower channels run fast
        assign chan_gap[c]  = !hw ? s.sync[c][6:0] :
                              (p.speed_sel || c < HS_CH_LOW) ? GAP_FAST_LEN : GAP_SLOW_LEN;

        qarx_rx_chan u_chan (
            .sys_clk     (sys_clk),
            .rst         (rst),
            .one_pulse   (p.one[c]),
            .zero_pulse  (p.zero[c]),
            .parity_en   (p.parity_en),
            .label_check (!hw),
            .enable      (chan_en[c]),
            .hold        (chan_hold[c]),
            .label_ref   (s.label[c]),
            .gap_len     (chan_gap[c]),
            .word_label  (chan_label[c]),
            .word_data   (chan_data[c]),
            .word_valid  (chan_valid[c])
        );
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s         = s;
        next_s.sy1     = pin_raw;
        next_s.sy2     = s.sy1;
        next_s.cs_prev = p.cs_n;
        next_s.irq_lvl = 1'b0;

        // Register writes
        if (wr) begin
            unique case ({p.addr})
                FA_CTRL_STAT: begin
                    next_s.ctrl = p.data;
                    if (p.data[CB_TX_PROG] && !s.ctrl[CB_TX_PROG]) begin
                        next_s.tx_idx = 2'h0;
                    end
                end
                FA_DIV: next_s.div = p.data;
                FA_TX_LABEL: begin
                    if (s.ctrl[CB_TX_PROG]) begin
                        for (int b = 0; b < WORD_BITS / LABEL_BITS; b++) begin
                            if (s.tx_idx == 2'(b)) begin
                                next_s.tx_sh[LABEL_BITS*b +: LABEL_BITS] = p.data;
                            end
                        end
                        next_s.tx_idx = s.tx_idx + 2'h1;
                    end else begin
                        for (int c = 0; c < NCH; c++) begin
                            if (s.ctrl[c]) begin
                                next_s.label[c] = p.data;
                            end
                        end
                    end
                end
                FA_SYNC: begin
                    for (int c = 0; c < NCH; c++) begin
                        if (s.ctrl[c]) begin
                            next_s.sync[c] = p.data;
                        end
                    end
                end
            endcase
        end

        // Buffer stays frozen from the first byte read to the last
        if (rd && !hw && p.addr != FA_CTRL_STAT) begin
            next_s.reading[rch] = (p.addr != FA_LAST_BYTE);
            if (p.addr == FA_LAST_BYTE) begin
                next_s.stat[rch] = 1'b0;
            end
        end
        if (s.ctrl[CB_TX_PROG]) begin
            next_s.stat[SB_TX_DONE] = 1'b0;
        end
        // New words set after any clear so none is lost
        for (int c = 0; c < NCH; c++) begin
            if (chan_valid[c] && !hw) begin
                next_s.stat[c] = 1'b1;
            end
        end

        // Transmitter: bit clock high half carries the pulse
        if (hw) begin
            next_s.stat[SB_TX_BUSY] = 1'b0;
        end else if (s.ctrl[CB_TX_GO] && !s.stat[SB_TX_BUSY]) begin
            next_s.stat[SB_TX_BUSY] = 1'b1;
            next_s.tx_bits  = 6'h00;
            next_s.tx_cnt   = 7'h00;
            next_s.tx_phase = 1'b1;
        end else if (s.stat[SB_TX_BUSY]) begin
            if (s.tx_cnt == 7'(half - 7'h01)) begin
                next_s.tx_cnt   = 7'h00;
                next_s.tx_phase = !s.tx_phase;
                if (!s.tx_phase) begin
                    next_s.tx_sh   = s.tx_sh >> 1;
                    next_s.tx_bits = s.tx_bits + 6'h01;
                    if (s.tx_bits == TX_LAST_BIT) begin
                        next_s.stat[SB_TX_BUSY] = 1'b0;
                        next_s.stat[SB_TX_DONE] = 1'b1;
                        next_s.ctrl[CB_TX_GO]   = 1'b0;
                        next_s.tx_phase         = 1'b0;
                    end
                end
            end else begin
                next_s.tx_cnt = s.tx_cnt + 7'h01;
            end
        end

        // Channel scan
        if (hw && !p.dir_hold) begin
            next_s.scan = s.scan + 2'h1;
        end
        if (hw) begin
            next_s.n0 = s.scan[0];
            next_s.n1 = s.scan[1];
        end else begin
            next_s.n0 = s.tx_phase && s.stat[SB_TX_BUSY] && !s.tx_sh[0];
            next_s.n1 = s.tx_phase && s.stat[SB_TX_BUSY] && s.tx_sh[0];
        end

        // Read data follows the address for the whole select period
        next_s.doe = !p.cs_n && (hw || p.dir_hold);
        if (hw) begin
            next_s.dout = (p.addr == FA_HW_LABEL) ? chan_label[rch] :
                          pick_byte(chan_data[rch], int'(p.addr));
        end else if (p.addr == FA_CTRL_STAT) begin
            next_s.dout = s.stat;
        end else begin
            next_s.dout = pick_byte(chan_data[rch], int'(p.addr) - 1);
        end

        next_s.irq_oe = !hw && ((|s.stat[NCH-1:0]) ||
                        (s.stat[SB_TX_DONE] && !s.ctrl[CB_IRQ_MASK]));
    end

    // Single clock for all timing
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s            <= '0;
            s.sy1.cs_n   <= 1'b1;
            s.sy2.cs_n   <= 1'b1;
            s.cs_prev    <= 1'b1;
            s.ctrl       <= CTRL_RST;
            s.div        <= DIV_RST;
            s.sync       <= {NCH{SYNC_RST}};
        end else begin
            s <= next_s;
        end
    end

    assign data_out                  = s.dout;
    assign data_oe                   = s.doe;
    assign zero_line_out_or_chan_lsb = s.n0;
    assign one_line_out_or_chan_msb  = s.n1;
    assign int_or_speed_sel_out      = s.irq_lvl;
    assign int_or_speed_sel_oe       = s.irq_oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_bus_release: assert property (@(posedge sys_clk) disable iff (rst)
        s.sy2.cs_n |=> !data_oe)
        else $error("bus driven while deselected");

    a_read_drive: assert property (@(posedge sys_clk) disable iff (rst)
        (!s.sy2.cs_n && !s.sy2.mode_hw) |=> (data_oe == $past(s.sy2.dir_hold)))
        else $error("bus drive does not follow direction");

    a_scan_frozen: assert property (@(posedge sys_clk) disable iff (rst)
        (s.sy2.mode_hw && s.sy2.dir_hold) |=> (s.scan == $past(s.scan)))
        else $error("scan moved while held");

    a_scan_step: assert property (@(posedge sys_clk) disable iff (rst)
        (s.sy2.mode_hw && !s.sy2.dir_hold) |=> (s.scan == 2'($past(s.scan) + 2'h1)))
        else $error("scan did not step");

    a_chan_number: assert property (@(posedge sys_clk) disable iff (rst)
        s.sy2.mode_hw |=> (zero_line_out_or_chan_lsb == $past(s.scan[0]) &&
                          one_line_out_or_chan_msb == $past(s.scan[1])))
        else $error("channel number not shown");

    a_tx_zero: assert property (@(posedge sys_clk) disable iff (rst)
        !s.sy2.mode_hw |=> (zero_line_out_or_chan_lsb ==
            ($past(s.tx_phase) && $past(s.stat[SB_TX_BUSY]) && !$past(s.tx_sh[0]))))
        else $error("zero line wrong");

    a_tx_one: assert property (@(posedge sys_clk) disable iff (rst)
        !s.sy2.mode_hw |=> (one_line_out_or_chan_msb ==
            ($past(s.tx_phase) && $past(s.stat[SB_TX_BUSY]) && $past(s.tx_sh[0]))))
        else $error("one line wrong");

    a_irq_input: assert property (@(posedge sys_clk) disable iff (rst)
        s.sy2.mode_hw |=> (!int_or_speed_sel_oe && !s.stat[SB_TX_BUSY]))
        else $error("interrupt or transmitter active in hardwired mode");

    a_hw_label: assert property (@(posedge sys_clk) disable iff (rst)
        (!s.sy2.cs_n && s.sy2.mode_hw && s.sy2.addr == FA_HW_LABEL)
        |=> (data_out == $past(chan_label[s.scan])))
        else $error("scanned label not on bus");

endmodule
`default_nettype wire

// *** logic/qarx_pkg.sv ***
`default_nettype none
package qarx_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NCH        = 4;
    localparam int WORD_BITS  = 32;
    localparam int LABEL_BITS = 8;
    localparam int DATA_BITS  = 24;
    localparam int GAP_PRESC  = 8;
    localparam int HS_CH_LOW  = 2;

    // ------------------------------------------------------------
    // Function addresses
    // ------------------------------------------------------------
    localparam logic [1:0] FA_CTRL_STAT = 2'h0;
    localparam logic [1:0] FA_DIV       = 2'h1;
    localparam logic [1:0] FA_TX_LABEL  = 2'h2;
    localparam logic [1:0] FA_SYNC      = 2'h3;
    localparam logic [1:0] FA_LAST_BYTE = 2'h3;
    localparam logic [1:0] FA_HW_LABEL  = 2'h3;

    // ------------------------------------------------------------
    // Control, status and sync fields
    // ------------------------------------------------------------
    localparam int CB_TX_PROG  = 4;
    localparam int CB_TX_GO    = 5;
    localparam int CB_IRQ_MASK = 7;
    localparam int SB_TX_DONE  = 4;
    localparam int SB_TX_BUSY  = 7;
    localparam int SYNC_EN     = 7;

    // ------------------------------------------------------------
    // Reset values and default gap lengths
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] DIV_RST   = 8'h02;
    localparam logic [7:0] SYNC_RST  = 8'h84;
    localparam logic [6:0] GAP_FAST  = 7'h04;
    localparam logic [6:0] GAP_SLOW  = 7'h10;

    typedef struct packed {
        logic       mode_hw;
        logic       parity_en;
        logic       speed_sel;
        logic       cs_n;
        logic       dir_hold;
        logic [1:0] addr;
        logic [7:0] data;
        logic [3:0] one;
        logic [3:0] zero;
    } qarx_pins_t;

endpackage
`default_nettype wire

// *** logic/qarx_rx_chan.sv ***
`timescale 1ns/10ps
`default_nettype none
module qarx_rx_chan (
    // Clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            rst,
    // Synchronised line pulses
    input  wire logic                            one_pulse,
    input  wire logic                            zero_pulse,
    // Configuration
    input  wire logic                            parity_en,
    input  wire logic                            label_check,
    input  wire logic                            enable,
    input  wire logic                            hold,
    input  wire logic [qarx_pkg::LABEL_BITS-1:0] label_ref,
    input  wire logic [6:0]                      gap_len,
    // Received word
    output logic      [qarx_pkg::LABEL_BITS-1:0] word_label,
    output logic      [qarx_pkg::DATA_BITS-1:0]  word_data,
    output logic                                 word_valid
);
    import qarx_pkg::*;

    localparam logic [5:0] BITCNT_FULL = 6'(WORD_BITS);
    localparam logic [5:0] BITCNT_LAST = 6'(WORD_BITS - 1);
    localparam logic [2:0] PRESC_LAST  = 3'(GAP_PRESC - 1);

    typedef struct packed {
        logic                  prev_clk;
        logic                  armed;
        logic [5:0]            bitcnt;
        logic [2:0]            presc;
        logic [6:0]            gapcnt;
        logic [WORD_BITS-1:0]  bits;
        logic [LABEL_BITS-1:0] label;
        logic [DATA_BITS-1:0]  data;
        logic                  valid;
    } qarx_chan_t;

    qarx_chan_t           s;
    qarx_chan_t           next_s;
    logic                 bclk;
    logic [WORD_BITS-1:0] word;

    assign bclk = one_pulse | zero_pulse;

    always_comb begin
        next_s          = s;
        next_s.valid    = 1'b0;
        next_s.prev_clk = bclk;
        word            = s.bits;
        word[s.bitcnt[4:0]] = one_pulse;
        if (bclk && !s.prev_clk && s.bitcnt < BITCNT_FULL) begin
            next_s.bits   = word;
            next_s.bitcnt = s.bitcnt + 6'h01;
            if (s.bitcnt == BITCNT_LAST && s.armed) begin
                next_s.armed = 1'b0;
                // Odd parity only, or no check at all
                if (enable && !hold && (!parity_en || ^word) &&
                    (!label_check || word[LABEL_BITS-1:0] == label_ref)) begin
                    next_s.label = word[LABEL_BITS-1:0];
                    next_s.data  = word[WORD_BITS-1:LABEL_BITS];
                    next_s.valid = 1'b1;
                end
            end
        end
        // Gap timer restarts on every falling edge of the recovered clock
        if (!bclk && s.prev_clk) begin
            next_s.presc  = 3'h0;
            next_s.gapcnt = 7'h00;
        end else if (!bclk) begin
            next_s.presc = s.presc + 3'h1;
            if (s.presc == PRESC_LAST && s.gapcnt != gap_len) begin
                next_s.gapcnt = s.gapcnt + 7'h01;
            end
            if (s.gapcnt == gap_len && gap_len != 7'h00) begin
                next_s.armed  = 1'b1;
                next_s.bitcnt = 6'h00;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign word_label = s.label;
    assign word_data  = s.data;
    assign word_valid = s.valid;

    a_parity_block: assert property (@(posedge sys_clk) disable iff (rst)
        (bclk && !s.prev_clk && s.armed && s.bitcnt == BITCNT_LAST && parity_en && !(^word))
        |=> !word_valid)
        else $error("even parity word was transferred");

    a_bit_value: assert property (@(posedge sys_clk) disable iff (rst)
        (bclk && !s.prev_clk && s.bitcnt < BITCNT_FULL)
        |=> (s.bits[$past(s.bitcnt[4:0])] == $past(one_pulse)))
        else $error("received bit does not follow its line");

endmodule
`default_nettype wire

// *** verification/qarx_line_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module qarx_line_model (
    // Clock
    input  wire logic       sys_clk,
    // Line pairs, idle low
    output logic      [3:0] one,
    output logic      [3:0] zero
);
    initial begin
        one = 4'h0;
        zero = 4'h0;
    end
    // Long idle first, so the receivers see a gap
    task automatic send(input logic [31:0] w, input logic [3:0] m);
        integer i;
        repeat (60) @(posedge sys_clk);
        for (i = 0; i < 32; i++) begin
            one <= w[i] ? m : 4'h0;
            zero <= w[i] ? 4'h0 : m;
            repeat (4) @(posedge sys_clk);
            one <= 4'h0;
            zero <= 4'h0;
            repeat (4) @(posedge sys_clk);
        end
        repeat (30) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// *** verification/tb_quad_arinc429_rx_interface.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_quad_arinc429_rx_interface;
    import qarx_pkg::*;
    logic       sys_clk = 1'b0, rst = 1'b1, mode_hw = 1'b0, cs_n = 1'b1, dir = 1'b0;
    logic [1:0] addr = 2'h0, c;
    logic [7:0] din = 8'h00, dout, q;
    logic [3:0] one, zero;
    logic       oe, z_out, o_out, int_out, int_oe;
    logic       par = 1'b1, txp = 1'b0;
    logic [31:0] w, tw, txw = 32'h0;
    integer     err_count = 0, checked = 0, seed = 24;
    always #25 sys_clk = ~sys_clk;
    qarx_top DUT (.sys_clk(sys_clk), .rst(rst), .mode_hw(mode_hw), .parity_en(par),
        .cs_n(cs_n), .dir_or_scan_hold(dir), .func_addr_low(addr[0]),
        .func_addr_high(addr[1]), .data_in(din), .data_out(dout), .data_oe(oe),
        .zero_pulse_in_ch0(zero[0]), .one_pulse_in_ch0(one[0]), .zero_pulse_in_ch1(zero[1]),
        .one_pulse_in_ch1(one[1]), .zero_pulse_in_ch2(zero[2]), .one_pulse_in_ch2(one[2]),
        .zero_pulse_in_ch3(zero[3]), .one_pulse_in_ch3(one[3]),
        .zero_line_out_or_chan_lsb(z_out), .one_line_out_or_chan_msb(o_out),
        .int_or_speed_sel_in(int_oe ? int_out : 1'b1), // Pull-up, all channels fast
        .int_or_speed_sel_out(int_out), .int_or_speed_sel_oe(int_oe));
    qarx_line_model u_line (.sys_clk(sys_clk), .one(one), .zero(zero));
    // Transmit monitor: one bit per pulse, value from the one line
    always @(posedge sys_clk) begin
        txp <= o_out | z_out;
        if (!mode_hw && (o_out | z_out) && !txp) txw <= {o_out, txw[31:1]};
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic rd, input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cs_n <= 1'b0;
        dir <= rd;
        addr <= a;
        din <= d;
        repeat (5) @(posedge sys_clk);
        q = dout;
        if (!mode_hw) chk("data_oe", {7'h0, rd}, {7'h0, oe});
        cs_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("data_oe idle", 8'h00, {7'h0, oe});
    endtask
    // Random payload, label in the low byte, parity bit on top
    function automatic logic [31:0] mk(input logic [7:0] lab, input logic odd);
        logic [31:0] v;
        v = $random(seed);
        v[7:0] = lab;
        v[31] = (^v[30:0]) ^ odd;
        return v;
    endfunction
    task automatic results;
        $display("Checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        err_count++;
        results();
    end
    // Labels are palindromes, so either bit order gives the same byte
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk("tx lines", 8'h00, {6'h0, o_out, z_out});
        chk("irq oe", 8'h00, {7'h0, int_oe});
        bus(1'b1, FA_CTRL_STAT, 8'h00);
        chk("status", 8'h00, q);
        bus(1'b0, FA_CTRL_STAT, 8'h0f);
        bus(1'b0, FA_TX_LABEL, 8'h3c);
        u_line.send(mk(8'h66, 1'b1), 4'hf);
        bus(1'b1, FA_CTRL_STAT, 8'h00);
        chk("status wrong label", 8'h00, q);
        u_line.send(mk(8'h3c, 1'b0), 4'hf);
        bus(1'b1, FA_CTRL_STAT, 8'h00);
        chk("status even word", 8'h00, q);
        w = mk(8'h3c, 1'b1);
        u_line.send(w, 4'h5);
        chk("irq oe", 8'h01, {7'h0, int_oe});
        bus(1'b1, FA_CTRL_STAT, 8'h00);
        chk("status good word", 8'h05, q);
        bus(1'b1, FA_DIV, 8'h00);
        chk("buffer byte0", w[15:8], q);
        bus(1'b1, FA_LAST_BYTE, 8'h00);
        chk("buffer byte2", w[31:24], q);
        bus(1'b1, FA_CTRL_STAT, 8'h00);
        chk("status after read", 8'h04, q);
        // Transmit a random word, lsb of the first byte first
        tw = $random(seed);
        bus(1'b0, FA_CTRL_STAT, 8'h10);
        for (int k = 0; k < 4; k++) bus(1'b0, FA_TX_LABEL, tw[8*k +: 8]);
        bus(1'b0, FA_CTRL_STAT, 8'h20);
        repeat (80) @(posedge sys_clk);
        for (int k = 0; k < 4; k++) chk("tx byte", tw[8*k +: 8], txw[8*k +: 8]);
        bus(1'b1, FA_CTRL_STAT, 8'h00);
        chk("status tx done", 8'h14, q);
        $display("software mode done");
        mode_hw <= 1'b1;
        u_line.send(mk(8'h99, 1'b1), 4'hf);
        chk("irq oe hw", 8'h00, {7'h0, int_oe});
        dir <= 1'b1;
        repeat (6) @(posedge sys_clk);
        c = {o_out, z_out};
        repeat (8) @(posedge sys_clk);
        chk("frozen scan", {6'h0, c}, {6'h0, o_out, z_out});
        dir <= 1'b0;
        @(posedge sys_clk);
        dir <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk("scan step", {6'h0, c + 2'h1}, {6'h0, o_out, z_out});
        // Each read spans 10 cycles, so reads run at 2 MHz while the scan stays held
        bus(1'b1, FA_HW_LABEL, 8'h00);
        chk("hw label", 8'h99, q);
        par <= 1'b0;
        w = mk(8'h5a, 1'b0);
        u_line.send(w, 4'hf);
        bus(1'b1, FA_HW_LABEL, 8'h00);
        chk("hw label no parity", 8'h5a, q);
        bus(1'b1, 2'h0, 8'h00);
        chk("hw byte0", w[15:8], q);
        $display("hardwired mode done");
        results();
    end
endmodule
`default_nettype wire
